// *** design/fws_timer.sv ***
// sector erase window timer, reloaded on every accepted sector erase command
// assumes load and cancel are one-cycle pulses on the same clock
`timescale 1ns/100ps
module fws_timer #(
	parameter int unsigned CYC = 6250
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// sequencer side
	fws_tmr_if.tmr t
);
	localparam int W = $clog2(CYC + 1);
	logic [W-1:0] cnt_r;
	logic run_r;
	logic exp_r;
	wire last = run_r && (cnt_r == W'(1));

	// load wins over a running count, so each load restarts the whole window
	always_ff @(posedge clk) begin
		if (srst || t.cancel) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			exp_r <= 1'b0;
		end else if (t.load) begin
			cnt_r <= W'(CYC);
			run_r <= 1'b1;
			exp_r <= 1'b0;
		end else if (run_r) begin
			cnt_r <= cnt_r - W'(1);
			run_r <= ~last;
			exp_r <= last;
		end
	end

	assign t.expired = exp_r;
endmodule // fws_timer

// *** design/fws_toggle.sv ***
// one toggling status bit
// assumes step is a one-cycle pulse per distinct read cycle
`timescale 1ns/100ps
module fws_toggle (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic clr,
	input wire logic step,
	// state
	output logic q
);
	logic q_r;

	// flip per read, restart from zero when a new operation is accepted from idle
	always_ff @(posedge clk) begin
		if (srst || clr) begin
			q_r <= 1'b0;
		end else if (step) begin
			q_r <= ~q_r;
		end
	end

	assign q = q_r;
endmodule // fws_toggle

// *** design/fws_top.sv ***
// write status reporting of one flash bank: status byte, toggle bits, busy pin
// assumes an APB master, a host read strobe on a pin, and an embedded
// algorithm engine on CLK that reports completion and pulse limit overrun
//
// Overview of operation
// RULE1 - toggle status is valid right after the command that starts an operation
// RULE2 - sector toggle flips only for erase-selected sectors, active or suspended
// RULE3 - device toggle flips during active erase, stops while suspended
// RULE4 - suspended: reads of unselected sectors return array data on all bits
// RULE5 - host reads the byte twice and compares the toggle bit
// RULE6 - toggle bit steady means done; next read returns array data
// RULE7 - still toggling: host checks fail bit, then compares once more
// RULE8 - toggling with fail bit high means failure; host issues reset
// RULE9 - host returning from other work restarts with a double read
// RULE10 - fail bit goes to one when pulse count limit is exceeded
// RULE11 - programming one over zero halts; fail bit rises at the limit
// RULE12 - reset after failure returns to read or to suspended read
// RULE13 - window bit reads zero in the erase window, one once erase runs
// RULE14 - each extra sector erase restarts the window; chip erase has none
// RULE15 - host with commands under fifty microseconds apart may skip window bit
// RULE16 - window bit one: only suspend is taken; zero: sector erases taken
// RULE17 - host confirms acceptance, checks window bit before and after
// RULE18 - host reads poll and sector toggle at a valid address
// RULE19 - reads outside the busy bank return array data
// RULE20 - suspended reads are served whether asynchronous or burst
// RULE21 - busy pin reports activity only in asynchronous mode
// RULE22 - busy pin low while programming or erasing, released otherwise
// RULE23 - poll bit is the complement of the programmed bit until done
// RULE24 - device toggle flips on reads to the busy bank, stops when done
// RULE25 - host re-asserts output enable or chip select between reads
// RULE26 - a toggling bit inverts on every distinct status read
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "fws_defs.svh"
module fws_top import fws_pkg::*; #(
	parameter int unsigned NSECT = 8,
	parameter int unsigned BANK_W = 2,
	parameter int unsigned ERASE_TO_CYC = `FWS_ERASE_TO_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// host read pins
	input wire logic RD_N,
	input wire logic [$clog2(NSECT)-1:0] RD_SECT,
	input wire logic [BANK_W-1:0] RD_BANK,
	output logic [7:0] DQ_O,
	output logic DQ_OE,
	// busy pin, open drain
	output logic BUSY_O,
	output logic BUSY_OE,
	// embedded algorithm engine
	input wire logic [7:0] ARRAY_DQ,
	input wire logic ENG_DONE,
	input wire logic ENG_LIMIT
);
	localparam int SW = $clog2(NSECT);

	// ****************************************
	// state
	// ****************************************
	fws_state_t state_r, state_nxt;
	logic [NSECT-1:0] sel_r, sel_nxt;
	logic fail_prog_r, fail_prog_nxt;
	logic fail_susp_r, fail_susp_nxt;
	logic pd7_r;
	logic [BANK_W-1:0] bank_r;
	logic [31:0] cfg_r;
	logic [31:0] cmd_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [7:0] dq_r;
	logic dq_oe_r;
	logic busy_oe_r;
	logic rdn_s1, rdn_s2, rdn_s3;
	logic [SW-1:0] sect_s1, sect_s2;
	logic [BANK_W-1:0] bank_s1, bank_s2;
	logic rd_d_r;
	logic tog_clr;
	logic dtog_q, stog_q;
	fws_tmr_if tmr ();

	// ****************************************
	// apb slave decode
	// ****************************************
	wire apb_acc = PSEL && PENABLE && !pready_r;
	wire hit_cfg = PADDR == `FWS_OFS_CFG;
	wire hit_cmd = PADDR == `FWS_OFS_CMD;
	wire hit_stat = PADDR == `FWS_OFS_STAT;
	wire hit_any = hit_cfg || hit_cmd || hit_stat;
	wire cfg_wr = PSEL && PENABLE && pready_r && PWRITE && hit_cfg; // acts with the answer
	wire cmd_wr = PSEL && PENABLE && pready_r && PWRITE && hit_cmd;
	wire [3:0] code = PWDATA[`FWS_CMD_CODE];
	wire [SW-1:0] w_sect = PWDATA[`FWS_CMD_SECT] < 4'(NSECT) ? SW'(PWDATA[`FWS_CMD_SECT]) : '0;
	wire [NSECT-1:0] w_sel = NSECT'(1) << w_sect;
	wire c_prog = cmd_wr && code == `FWS_C_PROG;
	wire c_serase = cmd_wr && code == `FWS_C_SERASE;
	wire c_cerase = cmd_wr && code == `FWS_C_CERASE;
	wire c_susp = cmd_wr && code == `FWS_C_SUSP;
	wire c_resume = cmd_wr && code == `FWS_C_RESUME;
	wire c_reset = cmd_wr && code == `FWS_C_RESET;
	wire async_mode = cfg_r[`FWS_CFG_ASYNC];
	wire [31:0] stat_word = (32'(sel_r) << 8) | 32'(state_r);
	wire [31:0] rd_mux = hit_cfg ? cfg_r : hit_cmd ? cmd_r : hit_stat ? stat_word : 32'h0000_0000;

	// one wait state per transfer; unmapped addresses answer with an error
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= apb_acc;
			pslverr_r <= apb_acc && !hit_any;
			prdata_r <= (apb_acc && !PWRITE) ? rd_mux : 32'h0000_0000;
		end
	end

	// configuration and last command
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cfg_r <= `FWS_CFG_RST;
			cmd_r <= 32'h0000_0000;
		end else begin
			if (cfg_wr) cfg_r <= PWDATA;
			if (cmd_wr) cmd_r <= PWDATA;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	wire st_idle = state_r == ST_IDLE;
	wire st_prog = state_r == ST_PROG;
	wire st_erwin = state_r == ST_ERWIN;
	wire st_erase = state_r == ST_ERASE;
	wire st_susp = state_r == ST_SUSP;
	wire st_sprog = state_r == ST_SPROG;
	wire st_fail = state_r == ST_FAIL;

	// next state; commands not listed for a state are dropped silently
	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		fail_prog_nxt = fail_prog_r;
		fail_susp_nxt = fail_susp_r;
		tmr.load = 1'b0;
		tmr.cancel = 1'b0;
		tog_clr = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (c_prog) begin
					state_nxt = ST_PROG;
					tog_clr = 1'b1; // RULE1
				end else if (c_serase) begin
					state_nxt = ST_ERWIN;
					sel_nxt = w_sel;
					tmr.load = 1'b1;
					tog_clr = 1'b1; // RULE1
				end else if (c_cerase) begin
					state_nxt = ST_ERASE; // RULE14
					sel_nxt = '1;
					tog_clr = 1'b1;
				end
			end
			ST_PROG: begin
				if (ENG_LIMIT) begin
					state_nxt = ST_FAIL; // RULE10 RULE11
					fail_prog_nxt = 1'b1;
					fail_susp_nxt = 1'b0;
				end else if (ENG_DONE) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_ERWIN: begin
				if (ENG_LIMIT) begin
					state_nxt = ST_FAIL; // RULE10
					fail_prog_nxt = 1'b0;
					tmr.cancel = 1'b1;
				end else if (c_serase) begin
					sel_nxt = sel_r | w_sel;
					tmr.load = 1'b1; // RULE14 RULE16
				end else if (c_susp) begin
					state_nxt = ST_SUSP;
					tmr.cancel = 1'b1;
				end else if (tmr.expired) begin
					state_nxt = ST_ERASE; // RULE13
				end
			end
			ST_ERASE: begin
				if (ENG_LIMIT) begin
					state_nxt = ST_FAIL; // RULE10
					fail_prog_nxt = 1'b0;
				end else if (ENG_DONE) begin
					state_nxt = ST_IDLE;
					sel_nxt = '0;
				end else if (c_susp) begin
					state_nxt = ST_SUSP; // RULE16
				end
			end
			ST_SUSP: begin
				if (c_resume) begin
					state_nxt = ST_ERASE;
				end else if (c_prog) begin
					state_nxt = ST_SPROG;
				end
			end
			ST_SPROG: begin
				if (ENG_LIMIT) begin
					state_nxt = ST_FAIL; // RULE10 RULE11
					fail_prog_nxt = 1'b1;
					fail_susp_nxt = 1'b1;
				end else if (ENG_DONE) begin
					state_nxt = ST_SUSP;
				end
			end
			ST_FAIL: begin
				if (c_reset) begin
					state_nxt = fail_susp_r ? ST_SUSP : ST_IDLE; // RULE12
					sel_nxt = fail_susp_r ? sel_r : '0;
					fail_susp_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				sel_nxt = '0;
			end
		endcase
	end

	// state registers
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_r <= ST_IDLE;
			sel_r <= '0;
			fail_prog_r <= 1'b0;
			fail_susp_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			fail_prog_r <= fail_prog_nxt;
			fail_susp_r <= fail_susp_nxt;
		end
	end

	// program datum bit and bank of the accepted operation
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pd7_r <= 1'b0;
			bank_r <= '0;
		end else begin
			if (c_prog && (st_idle || st_susp)) pd7_r <= PWDATA[`FWS_CMD_DATA7];
			if (st_idle && (c_prog || c_serase || c_cerase)) bank_r <= PWDATA[`FWS_CMD_BANK];
		end
	end

	fws_timer #(.CYC(ERASE_TO_CYC)) u_timer (
		.clk(CLK),
		.srst(SRST),
		.t(tmr.tmr)
	);

	// ****************************************
	// host read path
	// ****************************************
	// pins are foreign to CLK, so two flops before use
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdn_s1 <= 1'b1;
			rdn_s2 <= 1'b1;
			rdn_s3 <= 1'b1;
			sect_s1 <= '0;
			sect_s2 <= '0;
			bank_s1 <= '0;
			bank_s2 <= '0;
		end else begin
			rdn_s1 <= RD_N;
			rdn_s2 <= rdn_s1;
			rdn_s3 <= rdn_s2;
			sect_s1 <= RD_SECT;
			sect_s2 <= sect_s1;
			bank_s1 <= RD_BANK;
			bank_s2 <= bank_s1;
		end
	end

	// a read cycle begins at each new assertion, whatever the read mode
	wire rd_start = rdn_s3 && !rdn_s2; // RULE20 RULE25
	wire in_bank = bank_s2 == bank_r; // RULE19
	wire sect_sel = sel_r[sect_s2];
	wire prog_like = st_prog || st_sprog || (st_fail && fail_prog_r);
	wire erase_like = st_erwin || st_erase || st_susp || (st_fail && !fail_prog_r);
	wire dtog_en = !st_idle && !st_susp; // RULE3 RULE24
	wire stog_en = erase_like && sect_sel; // RULE2
	wire show_stat = in_bank && !st_idle && !(st_susp && !sect_sel); // RULE4 RULE19
	wire poll_bit = prog_like ? ~pd7_r : st_susp; // RULE23
	wire fail_bit = st_fail; // RULE10
	wire win_bit = st_erase || (st_fail && !fail_prog_r); // RULE13
	wire [7:0] stat_byte = {poll_bit, dtog_q, fail_bit, ARRAY_DQ[4], win_bit, stog_q, ARRAY_DQ[1:0]};

	// toggles advance once per distinct read of the busy bank
	fws_toggle u_dtog (
		.clk(CLK),
		.srst(SRST),
		.clr(tog_clr),
		.step(rd_start && in_bank && dtog_en), // RULE26
		.q(dtog_q)
	);

	fws_toggle u_stog (
		.clk(CLK),
		.srst(SRST),
		.clr(tog_clr),
		.step(rd_start && in_bank && stog_en), // RULE26
		.q(stog_q)
	);

	// byte is latched one cycle after the read starts, after the toggle flipped
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rd_d_r <= 1'b0;
			dq_r <= 8'h00;
			dq_oe_r <= 1'b0;
		end else begin
			rd_d_r <= rd_start;
			dq_oe_r <= !rdn_s2;
			if (rd_d_r) dq_r <= show_stat ? stat_byte : ARRAY_DQ;
		end
	end

	// busy pin only pulls low; release otherwise, and never in burst mode
	always_ff @(posedge CLK) begin
		if (SRST) begin
			busy_oe_r <= 1'b0;
		end else begin
			busy_oe_r <= async_mode && (st_prog || st_sprog || st_erwin || st_erase || st_fail); // RULE21 RULE22
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign DQ_O = dq_r;
	assign DQ_OE = dq_oe_r;
	assign BUSY_O = 1'b0;
	assign BUSY_OE = busy_oe_r;
endmodule // fws_top

// *** include/fws_defs.svh ***
// constants of the flash write status block: offsets, fields, command codes, timing
// assumes a 125 MHz core clock and a 32-bit APB register bus
`ifndef FWS_DEFS_SVH
`define FWS_DEFS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FWS_OFS_CFG 8'h00
`define FWS_OFS_CMD 8'h04
`define FWS_OFS_STAT 8'h08

// ****************************************
// fields
// ****************************************
`define FWS_CFG_ASYNC 0
`define FWS_CMD_CODE 3:0
`define FWS_CMD_SECT 7:4
`define FWS_CMD_DATA7 15
`define FWS_CMD_BANK 17:16
`define FWS_CFG_RST 32'h0000_0000

// ****************************************
// command codes
// ****************************************
`define FWS_C_PROG 4'h1
`define FWS_C_SERASE 4'h2
`define FWS_C_CERASE 4'h3
`define FWS_C_SUSP 4'h4
`define FWS_C_RESUME 4'h5
`define FWS_C_RESET 4'h6

// ****************************************
// timing
// ****************************************
`define FWS_CLK_MHZ 125
`define FWS_ERASE_TO_US 50
`define FWS_ERASE_TO_CYC (`FWS_ERASE_TO_US * `FWS_CLK_MHZ)

`endif

// *** include/fws_pkg.sv ***
// types of the flash write status block
// assumes nothing beyond the defs header
package fws_pkg;

	// one-hot states of the write status sequencer
	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_PROG = 7'b000_0010,
		ST_ERWIN = 7'b000_0100,
		ST_ERASE = 7'b000_1000,
		ST_SUSP = 7'b001_0000,
		ST_SPROG = 7'b010_0000,
		ST_FAIL = 7'b100_0000
	} fws_state_t;

endpackage

// *** include/fws_tmr_if.sv ***
// link between the sequencer and the sector erase window timer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface fws_tmr_if;
	logic load;
	logic cancel;
	logic expired;
	modport ctl (output load, output cancel, input expired);
	modport tmr (input load, input cancel, output expired);
endinterface

// *** testbench/fws_host_mdl.sv ***
// host side model: reads the status byte over the read pins, runs the toggle poll
// assumes the read pin timing of the flash status top level, one clock
`timescale 1ns/100ps
module fws_host_mdl (
	// clock
	input wire logic clk,
	// read pins
	output logic rd_n,
	output logic [2:0] rd_sect,
	output logic [1:0] rd_bank,
	input wire logic [7:0] dq,
	input wire logic dq_oe
);
	initial begin
		rd_n = 1'b1;
		rd_sect = 3'h0;
		rd_bank = 2'h0;
	end
	// one read cycle; address settles first, strobe rises between reads
	task automatic rd(input logic [2:0] s, input logic [1:0] b, output logic [7:0] q);
		@(posedge clk);
		rd_sect <= s;
		rd_bank <= b;
		repeat (3) @(posedge clk);
		rd_n <= 1'b0;
		repeat (6) @(posedge clk);
		q = dq_oe ? dq : 8'hxx; // a released bus never passes for data
		rd_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// toggle poll: 0 finished, 1 still running, 2 failed
	task automatic poll(input logic [2:0] s, input logic [1:0] b, output logic [1:0] r);
		logic [7:0] x;
		logic [7:0] y;
		rd(s, b, x);
		rd(s, b, y);
		if ($isunknown({x, y}))
			r = 2'h3; // an undriven byte never passes for a finished poll
		else if (x[6] === y[6])
			r = 2'h0;
		else if (y[5] !== 1'b1)
			r = 2'h1;
		else begin
			rd(s, b, x);
			r = (x[6] === y[6]) ? 2'h0 : 2'h2;
		end
	endtask
endmodule // fws_host_mdl

// *** testbench/fws_top_chk.sv ***
// assertion checker for the flash write status top level
// assumes it is bound to fws_top and sees only its ports, all on CLK
`timescale 1ns/100ps
`include "fws_defs.svh"
module fws_top_chk (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// read pins
	input wire logic RD_N,
	input wire logic [7:0] DQ_O,
	input wire logic DQ_OE,
	// busy pin and engine
	input wire logic BUSY_OE,
	input wire logic ENG_DONE
);
	// ****************************************
	// helper logic
	// ****************************************
	logic async_r;
	logic [3:0] hi_cnt_r;
	wire cfg_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == `FWS_OFS_CFG;
	// mode mirror and a saturating count of strobe-high cycles
	always_ff @(posedge CLK) begin
		async_r <= SRST ? 1'b0 : (cfg_wr ? PWDATA[`FWS_CFG_ASYNC] : async_r);
		hi_cnt_r <= (SRST || !RD_N) ? 4'h0 : hi_cnt_r + {3'h0, hi_cnt_r != 4'hF};
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	// ****************************************
	// properties
	// ****************************************
	property p_apb_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
	a_apb_wait: assert property (p_apb_wait)
		else $error("apb access not ended after one wait state");
	property p_ready_pulse; PREADY |=> !PREADY; endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready longer than one cycle");
	property p_idle_data; !PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR; endproperty
	a_idle_data: assert property (p_idle_data)
		else $error("read data or error outside the answer cycle");
	// the busy pin only works in asynchronous mode; mode may lag two edges
	property p_busy_sync; !async_r && !$past(async_r) && !$past(async_r, 2) |-> !BUSY_OE; endproperty
	a_busy_sync: assert property (p_busy_sync)
		else $error("busy pin pulled in burst mode");
	property p_busy_done; ENG_DONE && BUSY_OE |-> ##[1:2] !BUSY_OE; endproperty
	a_busy_done: assert property (p_busy_done)
		else $error("busy pin not released after completion");
	property p_oe_on; $fell(RD_N) |-> ##[2:4] DQ_OE; endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("read byte not driven after strobe fell");
	property p_oe_off; $rose(RD_N) |-> ##[2:4] !DQ_OE; endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("read byte still driven after strobe rose");
	// status bits advance only with a new read cycle
	property p_dq_hold; hi_cnt_r >= 4'h6 |-> $stable(DQ_O); endproperty
	a_dq_hold: assert property (p_dq_hold)
		else $error("read byte changed without a read cycle");
	c_err: cover property (PSLVERR);
	c_busy: cover property ($fell(BUSY_OE));
	c_read: cover property ($rose(DQ_OE));
endmodule // fws_top_chk

bind fws_top fws_top_chk i_fws_top_chk (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .RD_N(RD_N), .DQ_O(DQ_O), .DQ_OE(DQ_OE),
	.BUSY_OE(BUSY_OE), .ENG_DONE(ENG_DONE));

// *** testbench/tb_top.sv ***
// self-checking bench of the flash write status top level
// assumes the host model on the read pins and the bench as engine and apb master
`timescale 1ns/100ps
`include "fws_defs.svh"
module tb_top import fws_pkg::*; ;
	localparam int TO = 40;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, q;
	logic pready, pslverr, dq_oe, busy_o, busy_oe, e;
	logic eng_done = 1'b0;
	logic eng_limit = 1'b0;
	logic [7:0] array_dq = 8'h5A;
	logic [7:0] dq_o, a, b;
	logic [1:0] r;
	wire rd_n;
	wire [2:0] rd_sect;
	wire [1:0] rd_bank;
	int err_count = 0;
	int tests_run = 0;
	initial forever #4 clk = ~clk;
	fws_top #(.ERASE_TO_CYC(TO)) i_fws_top (.CLK(clk), .SRST(srst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .RD_N(rd_n), .RD_SECT(rd_sect),
		.RD_BANK(rd_bank), .DQ_O(dq_o), .DQ_OE(dq_oe), .BUSY_O(busy_o), .BUSY_OE(busy_oe),
		.ARRAY_DQ(array_dq), .ENG_DONE(eng_done), .ENG_LIMIT(eng_limit));
	fws_host_mdl i_fws_host_mdl (.clk(clk), .rd_n(rd_n), .rd_sect(rd_sect),
		.rd_bank(rd_bank), .dq(dq_o), .dq_oe(dq_oe));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic chb(input string n, input logic x, input logic g);
		chk(n, {31'h0, x}, {31'h0, g});
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("apb wait", 32'h0000_0002, 32'(n));
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d, q, e);
		chb("write error", 1'b0, e);
	endtask
	task automatic st(input fws_state_t s);
		apb(1'b0, `FWS_OFS_STAT, 32'h0000_0000, q, e);
		chk("state", 32'(s), 32'(q[6:0]));
	endtask
	function automatic logic [31:0] cmd(input logic [3:0] c, input logic [3:0] s, input logic d7);
		return {16'h0000, d7, 7'h00, s, c};
	endfunction
	task automatic eng(input logic lim);
		@(posedge clk);
		eng_done <= !lim;
		eng_limit <= lim;
		@(posedge clk);
		eng_done <= 1'b0;
		eng_limit <= 1'b0;
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		// registers after reset, unmapped place refused
		apb(1'b0, `FWS_OFS_CFG, 32'h0000_0000, q, e);
		chk("cfg reset", `FWS_CFG_RST, q);
		st(ST_IDLE);
		apb(1'b0, 8'h0C, 32'h0000_0000, q, e);
		chb("unmapped error", 1'b1, e);
		chk("unmapped data", 32'h0000_0000, q);
		wr(`FWS_OFS_CFG, 32'h0000_0001);
		$display("test registers done");
		// program in asynchronous mode
		wr(`FWS_OFS_CMD, cmd(`FWS_C_PROG, 4'h0, 1'b1));
		st(ST_PROG);
		chb("busy program", 1'b1, busy_oe);
		chb("busy level", 1'b0, busy_o);
		i_fws_host_mdl.rd(3'h0, 2'h0, a);
		i_fws_host_mdl.rd(3'h0, 2'h0, b);
		chb("poll bit", 1'b0, a[7]);
		chb("device toggle", ~a[6], b[6]);
		chb("sector toggle", a[2], b[2]);
		chb("fail bit", 1'b0, b[5]);
		i_fws_host_mdl.rd(3'h0, 2'h1, a);
		chk("other bank", 32'(array_dq), 32'(a));
		i_fws_host_mdl.poll(3'h0, 2'h0, r);
		chk("poll running", 32'h0000_0001, 32'(r));
		eng(1'b0);
		st(ST_IDLE);
		chb("busy idle", 1'b0, busy_oe);
		i_fws_host_mdl.poll(3'h0, 2'h0, r);
		chk("poll done", 32'h0000_0000, 32'(r));
		i_fws_host_mdl.rd(3'h0, 2'h0, a);
		chk("array after done", 32'(array_dq), 32'(a));
		$display("test program done");
		// sector erase, window restarted by a second sector
		wr(`FWS_OFS_CMD, cmd(`FWS_C_SERASE, 4'h2, 1'b0));
		st(ST_ERWIN);
		i_fws_host_mdl.rd(3'h2, 2'h0, a);
		chb("window open", 1'b0, a[3]);
		wr(`FWS_OFS_CMD, cmd(`FWS_C_SERASE, 4'h5, 1'b0));
		repeat (25) @(posedge clk);
		st(ST_ERWIN);
		repeat (TO) @(posedge clk);
		apb(1'b0, `FWS_OFS_STAT, 32'h0000_0000, q, e);
		chk("erase sectors", {16'h0000, 8'h24, 1'b0, ST_ERASE}, q);
		i_fws_host_mdl.rd(3'h5, 2'h0, a);
		i_fws_host_mdl.rd(3'h5, 2'h0, b);
		chb("window closed", 1'b1, b[3]);
		chb("erase poll", 1'b0, b[7]);
		chb("erase device toggle", ~a[6], b[6]);
		chb("erase sector toggle", ~a[2], b[2]);
		i_fws_host_mdl.rd(3'h0, 2'h0, a);
		i_fws_host_mdl.rd(3'h0, 2'h0, b);
		chb("unselected sector", a[2], b[2]);
		wr(`FWS_OFS_CMD, cmd(`FWS_C_PROG, 4'h1, 1'b1));
		st(ST_ERASE);
		$display("test erase done");
		// suspend, program in suspend failing, reset back to suspend
		wr(`FWS_OFS_CMD, cmd(`FWS_C_SUSP, 4'h0, 1'b0));
		st(ST_SUSP);
		chb("busy suspended", 1'b0, busy_oe);
		i_fws_host_mdl.rd(3'h5, 2'h0, a);
		i_fws_host_mdl.rd(3'h5, 2'h0, b);
		chb("suspend device toggle", a[6], b[6]);
		chb("suspend sector toggle", ~a[2], b[2]);
		chb("suspend poll", 1'b1, b[7]);
		i_fws_host_mdl.rd(3'h1, 2'h0, a);
		chk("suspend array", 32'(array_dq), 32'(a));
		wr(`FWS_OFS_CMD, cmd(`FWS_C_PROG, 4'h1, 1'b0));
		st(ST_SPROG);
		chb("busy suspend program", 1'b1, busy_oe);
		eng(1'b1);
		st(ST_FAIL);
		i_fws_host_mdl.rd(3'h1, 2'h0, a);
		chb("fail bit set", 1'b1, a[5]);
		wr(`FWS_OFS_CMD, cmd(`FWS_C_RESET, 4'h0, 1'b0));
		st(ST_SUSP);
		wr(`FWS_OFS_CMD, cmd(`FWS_C_RESUME, 4'h0, 1'b0));
		st(ST_ERASE);
		eng(1'b0);
		st(ST_IDLE);
		$display("test suspend done");
		// chip erase has no window; burst mode keeps the busy pin released
		wr(`FWS_OFS_CMD, cmd(`FWS_C_CERASE, 4'h0, 1'b0));
		st(ST_ERASE);
		eng(1'b0);
		wr(`FWS_OFS_CFG, 32'h0000_0000);
		wr(`FWS_OFS_CMD, cmd(`FWS_C_PROG, 4'h3, 1'b1));
		st(ST_PROG);
		chb("busy burst mode", 1'b0, busy_oe);
		eng(1'b1);
		st(ST_FAIL);
		wr(`FWS_OFS_CMD, cmd(`FWS_C_RESET, 4'h0, 1'b0));
		st(ST_IDLE);
		$display("test chip erase and burst mode done");
		results;
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		results;
	end
endmodule // tb_top
